// >>> gcr_pkg.sv
package gcr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CMD  = 6'h00;
    localparam logic [5:0] IDX_OPT1 = 6'h01;
    localparam logic [5:0] IDX_OPT2 = 6'h02;
    localparam logic [5:0] IDX_POSA = 6'h03;
    localparam logic [5:0] IDX_SPD  = 6'h04;
    localparam logic [5:0] IDX_FRC  = 6'h05;
    localparam logic [5:0] IDX_POSB = 6'h06;
    localparam logic [5:0] IDX_POSS = 6'h0c;
    localparam logic [5:0] IDX_STAT = 6'h10;

    localparam int CMD_ACT  = 0;
    localparam int CMD_MOD  = 1;
    localparam int CMD_GTO  = 3;
    localparam int CMD_ATR  = 4;
    localparam int OPT_ICF  = 2;
    localparam int OPT_ICS  = 3;
    localparam logic [7:0] CMD_MASK = 8'h1f;
    localparam logic [7:0] OPT_MASK = 8'h0c;
    localparam logic [7:0] REG_RST  = 8'h00;

    localparam logic [1:0] MODE_BASIC   = 2'h0;
    localparam logic [1:0] MODE_PINCH   = 2'h1;
    localparam logic [1:0] MODE_WIDE    = 2'h2;
    localparam logic [1:0] MODE_SCISSOR = 2'h3;

    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_NS      = 1000;
    localparam int BLANK_CYC     =
        (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        ST_RESET   = 3'h0,
        ST_CALIB   = 3'h1,
        ST_OPEN    = 3'h3,
        ST_SETMODE = 3'h2,
        ST_READY   = 3'h6,
        ST_RELEASE = 3'h7,
        ST_FAULT   = 3'h5
    } gcr_state_t;
endpackage

// >>> gcr_top.sv
`timescale 1ns/100ps
module gcr_top #(
    parameter int         AW       = 8,
    parameter logic [7:0] POS_LO   = 8'h03,
    parameter logic [7:0] POS_HI   = 8'hf0,
    parameter logic [7:0] SCI_HI   = 8'hc0,
    parameter logic [8:0] CUR_BASE = 9'h020
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_hsel,
    input  wire logic [AW-1:0] i_haddr,
    input  wire logic [1:0]    i_htrans,
    input  wire logic          i_hwrite,
    input  wire logic [2:0]    i_hsize,
    input  wire logic [31:0]   i_hwdata,
    input  wire logic          i_hready,
    output logic               o_hreadyout,
    output logic               o_hresp,
    output logic [31:0]        o_hrdata,
    input  wire logic          i_axes_done,
    input  wire logic          i_over_current,
    output logic               o_go,
    output logic               o_calibrate,
    output logic               o_open_all,
    output logic               o_slow,
    output logic [1:0]         o_mode,
    output logic               o_sci_indep,
    output logic [7:0]         o_pos_a,
    output logic [7:0]         o_pos_b,
    output logic [7:0]         o_pos_c,
    output logic [7:0]         o_pos_s,
    output logic [7:0]         o_speed,
    output logic [8:0]         o_cur_lim,
    output logic               o_fault,
    output logic               o_obj_det
);
    gcr_pkg::gcr_state_t st_r, st_nxt;
    logic [7:0] cmd_r, opt_r, posa_r, spd_r, frc_r, posb_r, poss_r;
    logic [1:0] cur_mode_r, s1_r, s2_r, s3_r, flt_r;
    logic [5:0] wa_r, ra_r;
    logic       wr_pend_r, rd_pend_r, rdy_r;
    logic [31:0] rdata_r;
    logic       armed_r, step_done, stop_r, stop_nxt, go_r, go_nxt;
    logic [7:0] blank_r;
    logic       calib_r, open_r, slow_r, sci_r, fault_r;
    logic [1:0] mode_r;
    logic [7:0] pa_r, pb_r, pc_r, ps_r, spo_r;
    logic [8:0] cur_r;
    logic       act, gto, atr, icf, ics, pf, acc;
    logic [1:0] mode_req;

    assign act      = cmd_r[gcr_pkg::CMD_ACT];
    assign gto      = cmd_r[gcr_pkg::CMD_GTO];
    assign atr      = cmd_r[gcr_pkg::CMD_ATR];
    assign mode_req = cmd_r[gcr_pkg::CMD_MOD +: 2];
    assign icf      = opt_r[gcr_pkg::OPT_ICF];
    assign ics      = opt_r[gcr_pkg::OPT_ICS];

    function automatic logic [7:0] clamp(input logic [7:0] v,
                                         input logic [7:0] hi);
        if (v < POS_LO)
            return POS_LO;
        else if (v > hi)
            return hi;
        return v;
    endfunction

    // AHB-Lite slave: writes zero-wait, reads take one wait state so
    // a read right after a write returns the new value
    assign acc = i_hsel & i_htrans[1] & i_hready;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rdy_r     <= 1'b1;
            wa_r      <= 6'h00;
            ra_r      <= 6'h00;
        end else begin
            wr_pend_r <= acc & i_hwrite & (i_hsize == gcr_pkg::HSIZE_WORD);
            rd_pend_r <= acc & ~i_hwrite;
            rdy_r     <= ~(acc & ~i_hwrite);
            if (acc) begin
                wa_r <= i_haddr[7:2];
                ra_r <= i_haddr[7:2];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rdata_r <= 32'h0;
        end else if (rd_pend_r) begin
            case (ra_r)
                gcr_pkg::IDX_CMD:  rdata_r <= {24'h0, cmd_r};
                gcr_pkg::IDX_OPT1: rdata_r <= {24'h0, opt_r};
                gcr_pkg::IDX_POSA: rdata_r <= {24'h0, posa_r};
                gcr_pkg::IDX_SPD:  rdata_r <= {24'h0, spd_r};
                gcr_pkg::IDX_FRC:  rdata_r <= {24'h0, frc_r};
                gcr_pkg::IDX_POSB: rdata_r <= {24'h0, posb_r};
                gcr_pkg::IDX_POSS: rdata_r <= {24'h0, poss_r};
                gcr_pkg::IDX_STAT: rdata_r <= {25'h0, stop_r, fault_r,
                                               cur_mode_r, st_r};
                default:           rdata_r <= 32'h0;
            endcase
        end
    end

    // Reserved bits are masked off; the reserved byte stores nothing
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            cmd_r  <= gcr_pkg::REG_RST;
            opt_r  <= gcr_pkg::REG_RST;
            posa_r <= gcr_pkg::REG_RST;
            spd_r  <= gcr_pkg::REG_RST;
            frc_r  <= gcr_pkg::REG_RST;
            posb_r <= gcr_pkg::REG_RST;
            poss_r <= gcr_pkg::REG_RST;
        end else if (wr_pend_r) begin
            case (wa_r)
                gcr_pkg::IDX_CMD:  cmd_r  <= i_hwdata[7:0] & gcr_pkg::CMD_MASK;
                gcr_pkg::IDX_OPT1: opt_r  <= i_hwdata[7:0] & gcr_pkg::OPT_MASK;
                gcr_pkg::IDX_POSA: posa_r <= i_hwdata[7:0];
                gcr_pkg::IDX_SPD:  spd_r  <= i_hwdata[7:0];
                gcr_pkg::IDX_FRC:  frc_r  <= i_hwdata[7:0];
                gcr_pkg::IDX_POSB: posb_r <= i_hwdata[7:0];
                gcr_pkg::IDX_POSS: poss_r <= i_hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Mechanism inputs: three stages, a change counts once 2 and 3 agree
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            s1_r  <= 2'h0;
            s2_r  <= 2'h0;
            s3_r  <= 2'h0;
            flt_r <= 2'h0;
        end else begin
            s1_r  <= {i_over_current, i_axes_done};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
        end
    end

    // A step ends only after done was seen low inside it, so a stale
    // done from the previous move cannot end the next one early
    assign step_done = armed_r & flt_r[0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst)
            armed_r <= 1'b0;
        else if (st_nxt != st_r)
            armed_r <= 1'b0;
        else
            armed_r <= armed_r | ~flt_r[0];
    end

    always_comb begin
        st_nxt = st_r;
        if (!act) begin
            st_nxt = gcr_pkg::ST_RESET;
        end else if (atr && st_r != gcr_pkg::ST_FAULT &&
                     st_r != gcr_pkg::ST_RELEASE) begin
            st_nxt = gcr_pkg::ST_RELEASE;
        end else begin
            case (st_r)
                gcr_pkg::ST_RESET:   st_nxt = gcr_pkg::ST_CALIB;
                gcr_pkg::ST_CALIB:
                    if (step_done) st_nxt = gcr_pkg::ST_SETMODE;
                gcr_pkg::ST_READY:
                    if (!ics && mode_req != cur_mode_r)
                        st_nxt = gcr_pkg::ST_OPEN;
                gcr_pkg::ST_OPEN:
                    if (step_done) st_nxt = gcr_pkg::ST_SETMODE;
                gcr_pkg::ST_SETMODE:
                    if (step_done) st_nxt = gcr_pkg::ST_READY;
                gcr_pkg::ST_RELEASE:
                    if (step_done) st_nxt = gcr_pkg::ST_FAULT;
                gcr_pkg::ST_FAULT:   st_nxt = gcr_pkg::ST_FAULT;
                default:             st_nxt = gcr_pkg::ST_RESET;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst)
            st_r <= gcr_pkg::ST_RESET;
        else
            st_r <= st_nxt;
    end

    // Mode only changes on leaving the set-mode step
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst)
            cur_mode_r <= gcr_pkg::MODE_BASIC;
        else if (st_r == gcr_pkg::ST_SETMODE && step_done && !ics)
            cur_mode_r <= mode_req;
    end

    // Contact stop: set wins over clearing by go-to low
    assign stop_nxt = (go_r & flt_r[1] & (blank_r == 8'h00)) |
                      (stop_r & act & gto);
    // Speed never enters here, so a speed write cannot start motion
    assign go_nxt = (st_nxt == gcr_pkg::ST_READY) & gto & ~stop_nxt;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            stop_r <= 1'b0;
            go_r   <= 1'b0;
        end else begin
            stop_r <= stop_nxt;
            go_r   <= go_nxt;
        end
    end

    // Inrush at motion start would trip the limit at once
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst)
            blank_r <= 8'h00;
        else if (go_nxt && !go_r)
            blank_r <= 8'(gcr_pkg::BLANK_CYC);
        else if (blank_r != 8'h00)
            blank_r <= blank_r - 8'h01;
    end

    assign pf = icf & ~(cur_mode_r == gcr_pkg::MODE_SCISSOR & ~ics);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            calib_r <= 1'b0;
            open_r  <= 1'b0;
            slow_r  <= 1'b0;
            fault_r <= 1'b0;
            mode_r  <= gcr_pkg::MODE_BASIC;
        end else begin
            calib_r <= st_nxt == gcr_pkg::ST_CALIB;
            open_r  <= st_nxt == gcr_pkg::ST_OPEN ||
                       st_nxt == gcr_pkg::ST_RELEASE;
            slow_r  <= st_nxt == gcr_pkg::ST_RELEASE;
            fault_r <= st_nxt == gcr_pkg::ST_FAULT;
            mode_r  <= (st_nxt == gcr_pkg::ST_SETMODE && !ics) ?
                       mode_req : cur_mode_r;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            sci_r <= 1'b0;
            pa_r  <= POS_LO;
            pb_r  <= POS_LO;
            pc_r  <= POS_LO;
            ps_r  <= POS_LO;
            spo_r <= 8'h00;
            cur_r <= CUR_BASE;
        end else begin
            sci_r <= ics;
            pa_r  <= clamp(posa_r, POS_HI);
            pb_r  <= clamp(pf ? posb_r : posa_r, POS_HI);
            pc_r  <= clamp(posa_r, POS_HI);
            ps_r  <= clamp(poss_r, SCI_HI);
            spo_r <= spd_r;
            cur_r <= 9'(CUR_BASE + {1'b0, frc_r});
        end
    end

    assign o_hreadyout = rdy_r;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = rdata_r;
    assign o_go        = go_r;
    assign o_calibrate = calib_r;
    assign o_open_all  = open_r;
    assign o_slow      = slow_r;
    assign o_mode      = mode_r;
    assign o_sci_indep = sci_r;
    assign o_pos_a     = pa_r;
    assign o_pos_b     = pb_r;
    assign o_pos_c     = pc_r;
    assign o_pos_s     = ps_r;
    assign o_speed     = spo_r;
    assign o_cur_lim   = cur_r;
    assign o_fault     = fault_r;
    assign o_obj_det   = stop_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    deact_reset_a: assert property (!act |=>
        st_r == gcr_pkg::ST_RESET && !fault_r && !go_r)
        else $error("deactivate did not reset");
    idle_still_a: assert property (st_r == gcr_pkg::ST_RESET |->
        !go_r && !open_r && !calib_r)
        else $error("motion while inactive");
    calib_start_a: assert property (act && !atr &&
        st_r == gcr_pkg::ST_RESET |=> calib_r ##0 !go_r)
        else $error("activation did not calibrate");
    mode_opens_a: assert property (act && !atr && !ics &&
        st_r == gcr_pkg::ST_READY && mode_req != cur_mode_r
        |=> open_r ##0 !go_r)
        else $error("mode change did not open first");
    ics_no_mode_a: assert property (act && !atr && ics &&
        st_r == gcr_pkg::ST_READY |=> st_r == gcr_pkg::ST_READY)
        else $error("mode honoured under scissor control");
    go_needs_bit_a: assert property (go_r |-> $past(gto))
        else $error("motion without go-to");
    release_prio_a: assert property (act && atr &&
        st_r inside {gcr_pkg::ST_READY, gcr_pkg::ST_OPEN}
        |=> slow_r && open_r && !go_r)
        else $error("release not taking priority");
    release_fault_a: assert property (act &&
        st_r == gcr_pkg::ST_RELEASE && step_done
        |=> fault_r ##1 (!go_r || !act))
        else $error("no fault after release");
    soft_limit_a: assert property (pa_r >= POS_LO && pa_r <= POS_HI &&
        pb_r <= POS_HI)
        else $error("position beyond software limit");
    sci_range_a: assert property ($rose(sci_r) ##1 sci_r |->
        ps_r <= SCI_HI)
        else $error("scissor beyond reduced range");
    contact_stop_a: assert property (go_r && flt_r[1] &&
        blank_r == 8'h00 |=> !go_r && stop_r)
        else $error("over-current did not stop");
    inrush_blank_a: assert property ($rose(go_r) |->
        blank_r == 8'(gcr_pkg::BLANK_CYC))
        else $error("no blanking at motion start");
    goto_stop_a: assert property (!gto |=> !go_r)
        else $error("motion with go-to clear");
    goto_move_a: assert property (act && !atr && gto &&
        st_r == gcr_pkg::ST_READY && !stop_nxt &&
        (ics || mode_req == cur_mode_r) |=> go_r)
        else $error("go-to did not start motion");
    spd_track_a: assert property (spo_r == $past(spd_r))
        else $error("speed not applied in real time");
    fault_still_a: assert property (fault_r |->
        !go_r && !calib_r && !open_r)
        else $error("motion while faulted");
    release_slow_a: assert property (st_r == gcr_pkg::ST_RELEASE |->
        open_r && slow_r)
        else $error("release not opening slowly");
    finger_b_a: assert property (!icf |=> pb_r == pa_r)
        else $error("finger B byte used without per-finger");
    mode_hold_a: assert property (ics |=>
        cur_mode_r == $past(cur_mode_r))
        else $error("mode changed under scissor control");
    motion_excl_a: assert property (calib_r || open_r |-> !go_r)
        else $error("go-to motion during routine");
endmodule

// >>> gcr_mech_model.sv
`timescale 1ns/100ps
// Mechanics stand-in: any change of calibrate, open_all, mode or go drops
// axes_done for a while, then raises it again as the move completes.
module gcr_mech_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_calibrate,
    input  wire logic       i_open_all,
    input  wire logic       i_slow,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_go,
    input  wire logic [7:0] i_delay,
    output logic            o_axes_done
);
    logic [4:0] cmd_r;
    logic [8:0] cnt_r;

    always_ff @(posedge i_sys_clk) begin
        cmd_r <= {i_calibrate, i_open_all, i_mode, i_go};
        if (!i_nrst) begin
            o_axes_done <= 1'b1;
            cnt_r       <= 9'h000;
        end else if (cmd_r != {i_calibrate, i_open_all, i_mode, i_go}) begin
            o_axes_done <= 1'b0;
            // Slow release takes twice as long
            cnt_r       <= i_slow ? {i_delay, 1'b0} : {1'b0, i_delay};
        end else if (cnt_r != 9'h000) begin
            cnt_r <= cnt_r - 9'h001;
        end else begin
            o_axes_done <= 1'b1;
        end
    end
endmodule

// >>> gripper_command_registers_tb_top.sv
`timescale 1ns/100ps
module gripper_command_registers_tb_top;
    logic        i_sys_clk;
    logic        i_nrst;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        over_cur;
    logic [7:0]  delay;
    wire         hready;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         done;
    wire         go;
    wire         calib;
    wire         open_all;
    wire         slow;
    wire  [1:0]  mode;
    wire         sci;
    wire  [7:0]  pos_a;
    wire  [7:0]  pos_b;
    wire  [7:0]  pos_c;
    wire  [7:0]  pos_s;
    wire  [7:0]  speed;
    wire  [8:0]  cur_lim;
    wire         fault;
    wire         obj;
    int          err_total;
    int          samples_checked;
    logic [31:0] rdv;
    logic [1:0]  m;

    gcr_top gcr_top_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_axes_done(done), .i_over_current(over_cur),
        .o_go(go), .o_calibrate(calib), .o_open_all(open_all),
        .o_slow(slow), .o_mode(mode), .o_sci_indep(sci), .o_pos_a(pos_a),
        .o_pos_b(pos_b), .o_pos_c(pos_c), .o_pos_s(pos_s),
        .o_speed(speed), .o_cur_lim(cur_lim), .o_fault(fault),
        .o_obj_det(obj));

    gcr_mech_model gcr_mech_model_inst (.i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst), .i_calibrate(calib), .i_open_all(open_all),
        .i_slow(slow), .i_mode(mode), .i_go(go), .i_delay(delay),
        .o_axes_done(done));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // One AHB single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [5:0] ix, input logic wr,
                        input logic [7:0] d, input logic [2:0] sz);
        @(posedge i_sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {ix, 2'b00};
        hwrite <= wr;
        hsize  <= sz;
        @(posedge i_sys_clk);
        while (hready !== 1'b1) @(posedge i_sys_clk);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge i_sys_clk);
        while (hready !== 1'b1) @(posedge i_sys_clk);
        rdv = hrdata;
        hsel   <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        xfer(ix, 1'b1, d, gcr_pkg::HSIZE_WORD);
    endtask

    task automatic rd(input logic [5:0] ix, input logic [7:0] exp);
        xfer(ix, 1'b0, 8'h00, gcr_pkg::HSIZE_WORD);
        chk(rdv, {24'h000000, exp});
    endtask

    task automatic wait_st(input gcr_pkg::gcr_state_t st);
        for (int i = 0; i < 300; i++) begin
            xfer(gcr_pkg::IDX_STAT, 1'b0, 8'h00, gcr_pkg::HSIZE_WORD);
            if (rdv[2:0] === st) break;
        end
        chk({29'h0, rdv[2:0]}, {29'h0, st});
    endtask

    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, over_cur} = '0;
        hsize = gcr_pkg::HSIZE_WORD;
        delay = 8'h14;
        i_nrst = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (6) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        cyc(4);
        chk(pos_a, 8'h03);
        chk(cur_lim, 9'h020);
        for (int i = 0; i < 7; i++) rd(i[5:0], 8'h00);
        rd(gcr_pkg::IDX_POSS, 8'h00);
        rd(6'h08, 8'h00);
        wr(gcr_pkg::IDX_OPT2, 8'h00);
        wr(6'h09, 8'h77);
        rd(6'h09, 8'h00);
        // Go-to and speed before activation must not move
        wr(gcr_pkg::IDX_CMD, 8'h08);
        wr(gcr_pkg::IDX_SPD, 8'h80);
        cyc(5);
        chk(go | calib | open_all, 1'b0);
        chk(speed, 8'h80);
        xfer(gcr_pkg::IDX_SPD, 1'b1, 8'h11, 3'h0);
        rd(gcr_pkg::IDX_SPD, 8'h80);
        wr(gcr_pkg::IDX_FRC, 8'h00);
        cyc(3);
        chk(cur_lim, 9'h020);
        wr(gcr_pkg::IDX_FRC, 8'h40);
        cyc(3);
        chk(cur_lim, 9'h060);
        wr(gcr_pkg::IDX_CMD, 8'h01);
        cyc(2);
        chk(calib, 1'b1);
        chk(go, 1'b0);
        wait_st(gcr_pkg::ST_READY);
        // Every mode, each one a change from the last
        for (int i = 1; i < 5; i++) begin
            m = i[1:0];
            wr(gcr_pkg::IDX_CMD, {5'h00, m, 1'b1});
            cyc(3);
            chk(open_all, 1'b1);
            chk(go, 1'b0);
            wait_st(gcr_pkg::ST_READY);
            chk(mode, m);
        end
        wr(gcr_pkg::IDX_POSA, 8'hff);
        cyc(3);
        chk(pos_a, 8'hf0);
        wr(gcr_pkg::IDX_POSA, 8'h80);
        wr(gcr_pkg::IDX_POSB, 8'h40);
        cyc(3);
        chk(pos_a, 8'h80);
        chk(pos_b, 8'h80);
        chk(pos_c, 8'h80);
        wr(gcr_pkg::IDX_OPT1, 8'h04);
        cyc(3);
        chk(pos_b, 8'h40);
        chk(pos_c, 8'h80);
        wr(gcr_pkg::IDX_OPT1, 8'h0c);
        wr(gcr_pkg::IDX_POSS, 8'hff);
        wr(gcr_pkg::IDX_CMD, 8'h07);
        cyc(5);
        chk(sci, 1'b1);
        chk(pos_s, 8'hc0);
        chk(open_all, 1'b0);
        chk(mode, 2'h0);
        wr(gcr_pkg::IDX_OPT1, 8'h00);
        wr(gcr_pkg::IDX_CMD, 8'h01);
        cyc(3);
        wait_st(gcr_pkg::ST_READY);
        wr(gcr_pkg::IDX_CMD, 8'h09);
        cyc(3);
        chk(go, 1'b1);
        @(posedge i_sys_clk);
        over_cur <= 1'b1;
        cyc(60);
        chk(go, 1'b1);
        cyc(50);
        chk(go, 1'b0);
        chk(obj, 1'b1);
        @(posedge i_sys_clk);
        over_cur <= 1'b0;
        wr(gcr_pkg::IDX_CMD, 8'h01);
        cyc(3);
        chk({go, obj}, 2'b00);
        wr(gcr_pkg::IDX_CMD, 8'h1b);
        cyc(3);
        chk({open_all, slow, go}, 3'b110);
        wait_st(gcr_pkg::ST_FAULT);
        chk(fault, 1'b1);
        wr(gcr_pkg::IDX_CMD, 8'h09);
        cyc(5);
        chk({go, calib, open_all}, 3'b000);
        wr(gcr_pkg::IDX_CMD, 8'h00);
        cyc(3);
        chk(fault, 1'b0);
        wait_st(gcr_pkg::ST_RESET);
        chk(hresp, 1'b0);
        complete_run();
    end
endmodule
